/* compressor_sequencer_protection_bench.sv */
// self-checking bench for the compressor sequencer
`default_nettype none
module compressor_sequencer_protection_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cps_pkg::*;
  logic clk_i = 0, rst_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
  logic s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic unit_auto_i = 1, ext_stop_i = 0, call_i = 0, stuck = 0;
  logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, cond_temp_i = 0;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, rd_v, rv;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic [15:0] cur_a_i, cur_b_i, cur_c_i;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] oil_sw_i, rev_i, rd_r, s_axi_bresp_o, s_axi_rresp_o;
  logic [1:0] comp_run_o, oil_sol_o, heater_o, load_sol_o, unload_sol_o;
  logic [1:0] fan_en_o, valve_step_o, valve_open_o, lt_ignore_o, diag_any_o;
  int n_mismatch = 0, n_compared = 0;
  time t1;
  cps_seq #(.TICK_CYCLES(10), .STEP_CYCLES(4)) u_cps_seq(.*);
  cps_far u_cps_far(.*);
  initial forever #5 clk_i = ~clk_i;
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  function automatic logic [7:0] exp_inh(input logic [7:0] v);
    return v < INH_MIN ? INH_MIN : v > INH_MAX ? INH_MAX : v;
  endfunction
  task to(input int n, lim);
    if (n >= lim) begin
      n_mismatch++;
      final_report;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    s_axi_bready_i <= 1;
    for (n = 0; n < 50 && !(s_axi_bvalid_o && s_axi_bready_i); n++) begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 0;
    end
    to(n, 50);
    chk(s_axi_bresp_o, RESP_OKAY);
    s_axi_bready_i <= 0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a);
    int n;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    s_axi_rready_i <= 1;
    for (n = 0; n < 50 && !(s_axi_rvalid_o && s_axi_rready_i); n++) begin
      @(posedge clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 0;
    end
    to(n, 50);
    rd_v = s_axi_rdata_o;
    rd_r = s_axi_rresp_o;
    s_axi_rready_i <= 0;
    @(posedge clk_i);
  endtask
  task wait_run(input logic [1:0] e, input int lim);
    int n;
    for (n = 0; n < lim && comp_run_o !== e; n++) @(posedge clk_i);
    to(n, lim);
  endtask
  initial begin
    rv = $urandom(32'h314d86f4);
    repeat (5) @(posedge clk_i);
    chk(heater_o, 2'b11);
    rst_i <= 0;
    cond_temp_i <= 8'($urandom);
    t1 = $time;
    @(posedge clk_i);
    rd(REG_CTRL);
    chk(rd_v, 32'(CTRL_RST));
    rv = $urandom_range(255, 100);
    wr(REG_CURLIM, rv);
    rd(REG_CURLIM);
    chk(rd_v, rv);
    rd(8'h42);
    chk(rd_r, RESP_SLVERR);
    call_i <= 1;
    wait_run(2'b01, 20000);
    chk(32'($time - t1 >= 120000), 1);
    chk({heater_o[0], oil_sol_o[0]}, 2'b01);
    chk({fan_en_o[0], lt_ignore_o[0]}, {1'b1, |cond_temp_i});
    wait_run(2'b11, 8000);
    ext_stop_i <= 1;
    t1 = $time;
    repeat (100) @(posedge clk_i);
    chk({comp_run_o[0], unload_sol_o[0], load_sol_o[0]}, 3'b110);
    wait_run(2'b00, 9000);
    chk(32'($time - t1 >= 20000), 1);
    chk({heater_o[0], unload_sol_o[0], diag_any_o[0]}, 3'b110);
    ext_stop_i <= 0;
    stuck <= 1;
    t1 = $time;
    wait_run(2'b01, 40000);
    chk(32'($time - t1 >= 300000), 1);
    ext_stop_i <= 1;
    wait_run(2'b00, 9000);
    rd(REG_DIAG);
    chk({diag_any_o[0], rd_v[6]}, 2'b11);
    wr(REG_INHIBIT, 32'h1);
    rd(REG_INHIBIT);
    chk(rd_v, 32'(INH_MIN));
    rv = $urandom;
    wr(REG_INHIBIT, rv);
    rd(REG_INHIBIT);
    chk(rd_v, 32'(exp_inh(rv[7:0])));
    unit_auto_i <= 0;
    repeat (5) @(posedge clk_i);
    chk(diag_any_o, 2'b00);
    rd(REG_STATUS);
    chk(rd_v[11], 1);
    final_report;
  end
endmodule // compressor_sequencer_protection_bench
bind cps_seq cps_seq_asserts u_cps_seq_asserts(.*);
`default_nettype wire

/* cps_far.sv */
// compressors, oil switches and current sensors around the sequencer
`default_nettype none
module cps_far(
  input wire logic clk_i,
  input wire logic stuck,
  input wire logic [1:0] comp_run_o,
  input wire logic [1:0] oil_sol_o,
  output logic [1:0] oil_sw_i,
  output logic [1:0] rev_i,
  output logic [15:0] cur_a_i, cur_b_i, cur_c_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // switch opens a cycle after oil stops, unless the bench sticks it
  always_ff @(posedge clk_i) oil_sw_i <= oil_sol_o | {2{stuck}};
  // flat 80 percent: load pulses never raise the draw
  assign cur_a_i = {comp_run_o[1] ? 8'd80 : 8'd0,
    comp_run_o[0] ? 8'd80 : 8'd0};
  assign cur_b_i = cur_a_i;
  assign cur_c_i = cur_a_i;
  assign rev_i = 2'b00;
endmodule // cps_far
`default_nettype wire

/* cps_pkg.sv */
// constants, register map and state type for the compressor sequencer
`default_nettype none
package cps_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int VALVE_SPS = 25;
  localparam int STEP_CYC = CLK_HZ / VALVE_SPS;
  localparam int VALVE_STROKE = 757;
  // times in seconds, counts in ticks
  localparam int T_RUN_UNLOAD_S = 20;
  localparam int T_OIL_S = 10;
  localparam int T_LONG_OFF_S = 300;
  localparam int T_SHORT_OFF_S = 10;
  localparam int T_MIN_RUN_S = 300;
  localparam int T_INH_MAX_S = 120;
  localparam int T_INH_MIN_S = 30;
  localparam int T_POST_S = 3600;
  localparam int T_CONT_S = 5;
  localparam int T_LOSS_S = 2;
  localparam int T_RV_S = 3;
  localparam int T_ROT_S = 1;
  localparam int T_PULSE_S = 1;
  localparam int T_OL_TRIP_S = 60;
  localparam int TK_S = 1000 / TICK_MS;
  localparam logic [15:0] RUN_UNLOAD_TK = 16'(T_RUN_UNLOAD_S * TK_S);
  localparam logic [15:0] OIL_TK = 16'(T_OIL_S * TK_S);
  localparam logic [15:0] LONG_OFF_TK = 16'(T_LONG_OFF_S * TK_S);
  localparam logic [15:0] SHORT_OFF_TK = 16'(T_SHORT_OFF_S * TK_S);
  localparam logic [15:0] MIN_RUN_TK = 16'(T_MIN_RUN_S * TK_S);
  localparam logic [15:0] POST_TK = 16'(T_POST_S * TK_S);
  localparam logic [15:0] CONT_TK = 16'(T_CONT_S * TK_S);
  localparam logic [15:0] LOSS_TK = 16'(T_LOSS_S * TK_S);
  localparam logic [15:0] RV_TK = 16'(T_RV_S * TK_S);
  localparam logic [15:0] ROT_TK = 16'(T_ROT_S * TK_S);
  localparam logic [15:0] PULSE_TK = 16'(T_PULSE_S * TK_S);
  localparam logic [15:0] TK_PER_S = 16'(TK_S);
  localparam logic [7:0] INH_MAX = 8'(T_INH_MAX_S);
  localparam logic [7:0] INH_MIN = 8'(T_INH_MIN_S);
  // currents in percent of rated_load_current
  localparam logic [7:0] PCT_TRIP = 8'd140;
  localparam logic [7:0] PCT_HOLD = 8'd125;
  localparam logic [7:0] PCT_LOSS = 8'd12;
  localparam logic [7:0] PCT_UNB_EN = 8'd15;
  localparam logic [7:0] PCT_UNB_DIS = 8'd30;
  localparam logic [7:0] PCT_LIMIT = 8'd120;
  localparam logic [7:0] PCT_CENT = 8'd100;
  localparam int OL_ACC_LIM = (140 - 125) * T_OL_TRIP_S * TK_S;
  // diagnostic bit positions
  localparam int D_OL = 0;
  localparam int D_CONT = 1;
  localparam int D_LOSS = 2;
  localparam int D_ROT = 3;
  localparam int D_UNB15 = 4;
  localparam int D_UNB30 = 5;
  localparam int DIAG_P = 6;
  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INHIBIT = 8'h04;
  localparam logic [7:0] REG_CURLIM = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_DIAG = 8'h10;
  localparam logic [7:0] REG_STARTS = 8'h14;
  localparam logic [7:0] REG_HOURS0 = 8'h18;
  localparam logic [7:0] REG_HOURS1 = 8'h1c;
  localparam int C_LEADLAG = 0;
  localparam int C_UNB_EN = 1;
  localparam int C_RV_EN = 2;
  localparam int C_MRESET = 3;
  localparam logic [2:0] CTRL_RST = 3'h2;
  localparam logic [7:0] CURLIM_RST = 8'h64;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_OFF, ST_POSITION, ST_RUN, ST_UNLOAD, ST_OIL
  } cps_state_e;
endpackage
`default_nettype wire

/* cps_prot.sv */
// current-based protection for one compressor
`default_nettype none
module cps_prot import cps_pkg::*; #(
  parameter int OL_LIMIT = OL_ACC_LIM
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic on_i,
  input wire logic unb_en_i,
  input wire logic rv_en_i,
  input wire logic rev_i,
  input wire logic clear_i,
  input wire logic [7:0] ia_i,
  input wire logic [7:0] ib_i,
  input wire logic [7:0] ic_i,
  output logic [DIAG_P-1:0] diag_o,
  output logic limit_o,
  output logic [9:0] sum_o
);
  logic [7:0] mx, mn, pct;
  logic [9:0] sum;
  logic [11:0] dev;
  logic [19:0] lhs, rhs;
  logic any_low, all_low, on_d_reg, cont_arm_reg;
  logic [15:0] since_reg, loss_reg, cont_reg;
  logic [31:0] ol_reg;
  logic [DIAG_P-1:0] set;

  always_comb begin
    mx = (ia_i > ib_i) ? ia_i : ib_i;
    mx = (ic_i > mx) ? ic_i : mx;
    mn = (ia_i < ib_i) ? ia_i : ib_i;
    mn = (ic_i < mn) ? ic_i : mn;
    sum = 10'(ia_i) + 10'(ib_i) + 10'(ic_i);
    any_low = mn < PCT_LOSS;
    all_low = mx < PCT_LOSS;
    // unbalance as (max - avg) / avg, kept free of division
    dev = 12'(mx) * 12'd3 - 12'(sum);
    pct = unb_en_i ? PCT_UNB_EN : PCT_UNB_DIS;
    lhs = 20'(dev) * 20'(PCT_CENT);
    rhs = 20'(pct) * 20'(sum);
    set = '0;
    set[D_OL] = ol_reg >= 32'(OL_LIMIT);
    set[D_LOSS] = loss_reg >= LOSS_TK;
    set[D_ROT] = on_i && rev_i && since_reg <= ROT_TK;
    set[D_CONT] = cont_arm_reg && cont_reg == '0 && !all_low;
    if (on_i && since_reg > ROT_TK && lhs >= rhs) begin
      set[unb_en_i ? D_UNB15 : D_UNB30] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !on_i) since_reg <= '0;
    else if (tick_i && since_reg != '1) since_reg <= since_reg + 16'd1;
  end

  // phase loss is blind while a reduced-voltage start transitions
  always_ff @(posedge clk_i) begin
    if (rst_i || !on_i || !any_low || (rv_en_i && since_reg < RV_TK)) begin
      loss_reg <= '0;
    end else if (tick_i && loss_reg != '1) begin
      loss_reg <= loss_reg + 16'd1;
    end
  end

  always_ff @(posedge clk_i) begin
    on_d_reg <= rst_i ? 1'b0 : on_i;
    if (rst_i) begin
      cont_arm_reg <= 1'b0;
      cont_reg <= '0;
    end else if (on_d_reg && !on_i) begin
      cont_arm_reg <= 1'b1;
      cont_reg <= CONT_TK;
    end else if (cont_arm_reg && (all_low || cont_reg == '0)) begin
      cont_arm_reg <= 1'b0;
    end else if (tick_i && cont_reg != '0) begin
      cont_reg <= cont_reg - 16'd1;
    end
  end

  // thermal integrator: grows above must-hold, bleeds off below it
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) ol_reg <= '0;
    else if (tick_i && mx >= PCT_HOLD) ol_reg <= ol_reg + 32'(mx - PCT_HOLD);
    else if (tick_i && ol_reg != '0) ol_reg <= ol_reg - 32'd1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      diag_o <= '0;
      limit_o <= 1'b0;
      sum_o <= '0;
    end else begin
      diag_o <= (clear_i ? '0 : diag_o) | set;
      limit_o <= mx > PCT_LIMIT;
      sum_o <= sum;
    end
  end
endmodule // cps_prot
`default_nettype wire

/* cps_seq.sv */
// two-compressor sequencer with protection and register slave
// Operation
// - lead/lag off: compressor 0 starts first when ready, else compressor 1
// - lead/lag on: compressor with fewest starts starts first
// - start unloaded; stop unloaded unless manual-reset diagnostic
// - load lead fully, unload it, start lag, then load equally
// - stage next compressor when load pulses raise no current
// - on falling demand stop the compressor with most run time
// - anti-recycle holds restart five minutes after unit off
// - ten second off time after long run ended on temperature
// - restart inhibit after power-up or manual reset, 30 to 120 s
// - start: inhibit expires, valve to start, unload on, load off
// - then compressor, oil on, heater off, ignore time, fans
// - switch or external stop: twenty seconds running unloaded
// - switch stop queues reset until run-unload finishes
// - oil off, ten seconds for oil switch to open, else diagnostic
// - stopped: heater on, unload held sixty minutes, load off
// - valve closes at 25 steps per second once compressor off
// - overload curve 125 hold, 140 trip, stops circuit partner
// - currents must fall below 12 percent within 5 s of release
// - phase below 12 percent for 2 s trips, except 3 s transition
// - reverse rotation within one second of start trips both
// - unbalance trips at 15 percent enabled, 30 percent disabled
// - unload above 120 percent or at chiller current limit
`default_nettype none
module cps_seq import cps_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int STEP_CYCLES = STEP_CYC,
  parameter logic [9:0] VALVE_START = 10'h0c8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic unit_auto_i,
  input wire logic ext_stop_i,
  input wire logic call_i,
  input wire logic [1:0] oil_sw_i,
  input wire logic [15:0] cur_a_i,
  input wire logic [15:0] cur_b_i,
  input wire logic [15:0] cur_c_i,
  input wire logic [1:0] rev_i,
  input wire logic [7:0] cond_temp_i,
  output logic [1:0] comp_run_o,
  output logic [1:0] oil_sol_o,
  output logic [1:0] heater_o,
  output logic [1:0] load_sol_o,
  output logic [1:0] unload_sol_o,
  output logic [1:0] fan_en_o,
  output logic [1:0] valve_step_o,
  output logic [1:0] valve_open_o,
  output logic [1:0] lt_ignore_o,
  output logic [1:0] diag_any_o
);
  localparam int NC = 2;
  logic [31:0] tdiv_reg, sdiv_reg;
  logic tick, step;
  logic [4:0] s1_reg, s2_reg;
  logic auto_s, estop_s, call_s, auto_d_reg, stop_all;
  logic [1:0] oil_s;
  logic [2:0] ctrl_reg;
  logic [7:0] inh_reg, lim_reg;
  logic mrst_wr, mrst, q_reset_reg;
  logic [15:0] inhibit_reg;
  cps_state_e st_reg [NC];
  logic [15:0] tmr_reg [NC], off_reg [NC], post_reg [NC], run_reg [NC];
  logic [15:0] ign_reg [NC], starts_reg [NC];
  logic [31:0] hours_reg [NC];
  logic [9:0] pos_reg [NC], sum [NC];
  logic [NC-1:0] oil_diag_reg, limit, start_req, stop_req, ready;
  logic [DIAG_P-1:0] diag [NC];
  logic [NC-1:0] trip;
  logic lead, any_unl, all_off, chil_lim;
  logic [1:0] nrun;
  logic [15:0] lp_reg, stg_reg;
  logic [10:0] prev_reg, both_sum;
  logic pulse_reg, pulsed_reg, stg_go;

  // common timebase and valve step rate
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) tdiv_reg <= '0;
    else tdiv_reg <= tdiv_reg + 32'd1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || step) sdiv_reg <= '0;
    else sdiv_reg <= sdiv_reg + 32'd1;
  end
  assign tick = tdiv_reg == 32'(TICK_CYCLES - 1);
  assign step = sdiv_reg == 32'(STEP_CYCLES - 1);

  always_ff @(posedge clk_i) begin
    s1_reg <= {oil_sw_i, call_i, ext_stop_i, unit_auto_i};
    s2_reg <= s1_reg;
    auto_d_reg <= rst_i ? 1'b1 : auto_s;
  end
  assign {oil_s, call_s, estop_s, auto_s} = s2_reg;
  assign stop_all = !auto_s || estop_s;

  // register slave
  logic aw_have_reg, w_have_reg;
  logic [7:0] awa_reg;
  logic [31:0] wd_reg;
  logic [3:0] ws_reg;
  logic wr_en, wr_hit, rd_hit;
  logic [31:0] rd_val;
  assign s_axi_awready_o = !aw_have_reg && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_have_reg && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign wr_en = aw_have_reg && w_have_reg;
  assign wr_hit = awa_reg <= REG_HOURS1 && awa_reg[1:0] == 2'b00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      awa_reg <= '0;
      wd_reg <= '0;
      ws_reg <= '0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_reg <= 1'b1;
        awa_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_reg <= 1'b1;
        wd_reg <= s_axi_wdata_i;
        ws_reg <= s_axi_wstrb_i;
      end
      if (wr_en) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
      inh_reg <= INH_MAX;
      lim_reg <= CURLIM_RST;
    end else if (wr_en && ws_reg[0]) begin
      if (awa_reg == REG_CTRL) begin
        ctrl_reg <= wd_reg[2:0];
      end else if (awa_reg == REG_INHIBIT) begin
        // clamp to the adjustable range
        inh_reg <= wd_reg[7:0] < INH_MIN ? INH_MIN :
                   wd_reg[7:0] > INH_MAX ? INH_MAX : wd_reg[7:0];
      end else if (awa_reg == REG_CURLIM) begin
        lim_reg <= wd_reg[7:0];
      end
    end
  end
  assign mrst_wr = wr_en && ws_reg[0] && awa_reg == REG_CTRL &&
                   wd_reg[C_MRESET];

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (s_axi_araddr_i == REG_CTRL) begin
      rd_val[2:0] = ctrl_reg;
    end else if (s_axi_araddr_i == REG_INHIBIT) begin
      rd_val[7:0] = inh_reg;
    end else if (s_axi_araddr_i == REG_CURLIM) begin
      rd_val[7:0] = lim_reg;
    end else if (s_axi_araddr_i == REG_STATUS) begin
      rd_val[11:0] = {inhibit_reg != '0, q_reset_reg, limit,
                      1'b0, 3'(st_reg[1]), 1'b0, 3'(st_reg[0])};
    end else if (s_axi_araddr_i == REG_DIAG) begin
      rd_val[15:0] = {1'b0, oil_diag_reg[1], diag[1],
                      1'b0, oil_diag_reg[0], diag[0]};
    end else if (s_axi_araddr_i == REG_STARTS) begin
      rd_val = {starts_reg[1], starts_reg[0]};
    end else if (s_axi_araddr_i == REG_HOURS0) begin
      rd_val = hours_reg[0];
    end else if (s_axi_araddr_i == REG_HOURS1) begin
      rd_val = hours_reg[1];
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_val;
      s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // protection, one per compressor
  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_prot
      cps_prot u_prot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .on_i(comp_run_o[g]),
        .unb_en_i(ctrl_reg[C_UNB_EN]),
        .rv_en_i(ctrl_reg[C_RV_EN]),
        .rev_i(rev_i[g]),
        .clear_i(mrst),
        .ia_i(cur_a_i[g*8 +: 8]),
        .ib_i(cur_b_i[g*8 +: 8]),
        .ic_i(cur_c_i[g*8 +: 8]),
        .diag_o(diag[g]),
        .limit_o(limit[g]),
        .sum_o(sum[g])
      );
      assign diag_any_o[g] = (|diag[g]) || oil_diag_reg[g];
    end
  endgenerate
  // a trip on either compressor takes its circuit partner down
  assign trip = {NC{|{diag[0], diag[1]}}};

  // switch stop resets only after run-unload has finished
  always_ff @(posedge clk_i) begin
    if (rst_i) q_reset_reg <= 1'b0;
    else if (auto_d_reg && !auto_s) q_reset_reg <= 1'b1;
    else if (mrst) q_reset_reg <= 1'b0;
  end
  assign mrst = mrst_wr || (q_reset_reg && !any_unl);

  always_ff @(posedge clk_i) begin
    if (rst_i) inhibit_reg <= 16'(INH_MAX) * TK_PER_S;
    else if (mrst) inhibit_reg <= 16'(inh_reg) * TK_PER_S;
    else if (tick && inhibit_reg != '0) inhibit_reg <= inhibit_reg - 16'd1;
  end

  // staging decisions
  always_comb begin
    any_unl = 1'b0;
    all_off = 1'b1;
    nrun = '0;
    for (int k = 0; k < NC; k++) begin
      any_unl = any_unl || st_reg[k] == ST_UNLOAD || st_reg[k] == ST_OIL;
      all_off = all_off && st_reg[k] == ST_OFF;
      nrun = nrun + 2'(st_reg[k] == ST_RUN);
      ready[k] = st_reg[k] == ST_OFF && off_reg[k] == '0 &&
                 inhibit_reg == '0 && !diag_any_o[k] &&
                 !stop_all && call_s;
    end
    lead = ctrl_reg[C_LEADLAG] &&
           starts_reg[1] < starts_reg[0];
    chil_lim = 11'(sum[0]) + 11'(sum[1]) >=
               11'(lim_reg) * 11'(3 * NC);
    start_req = '0;
    stop_req = '0;
    if (all_off) begin
      if (ready[lead]) start_req[lead] = 1'b1;
      else start_req[!lead] = ready[!lead];
    end else if (stg_go) begin
      start_req = ready;
    end
    if (!call_s && nrun != '0 && !any_unl) begin
      if (nrun == 2'd2) stop_req[hours_reg[1] > hours_reg[0]] = 1'b1;
      else stop_req = {st_reg[1] == ST_RUN, st_reg[0] == ST_RUN};
    end
  end

  // load pulses; no current rise means the running one is full
  always_ff @(posedge clk_i) begin
    if (rst_i || !call_s || nrun == '0 || any_unl) begin
      lp_reg <= PULSE_TK;
      pulse_reg <= 1'b0;
      pulsed_reg <= 1'b0;
      prev_reg <= '0;
      stg_reg <= '0;
    end else if (stg_reg != '0) begin
      pulse_reg <= 1'b0;
      if (tick) stg_reg <= stg_reg - 16'd1;
    end else if (tick && lp_reg == '0) begin
      lp_reg <= PULSE_TK;
      prev_reg <= both_sum;
      if (nrun == 2'd1 && pulsed_reg && both_sum <= prev_reg) begin
        stg_reg <= RUN_UNLOAD_TK;
        pulsed_reg <= 1'b0;
      end else begin
        pulse_reg <= 1'b1;
        pulsed_reg <= 1'b1;
      end
    end else if (tick) begin
      lp_reg <= lp_reg - 16'd1;
      pulse_reg <= 1'b0;
    end
  end
  assign stg_go = stg_reg == 16'd1 && tick;
  assign both_sum = 11'(sum[0]) + 11'(sum[1]);

  // per-compressor start and stop sequences
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < NC; k++) begin
      if (rst_i) begin
        st_reg[k] <= ST_OFF;
        tmr_reg[k] <= '0;
        off_reg[k] <= '0;
        post_reg[k] <= '0;
        run_reg[k] <= '0;
        ign_reg[k] <= '0;
        starts_reg[k] <= '0;
        hours_reg[k] <= '0;
        oil_diag_reg[k] <= 1'b0;
      end else begin
        if (tick && tmr_reg[k] != '0) tmr_reg[k] <= tmr_reg[k] - 16'd1;
        // min-off counts from contactor release, not from run-unload
        if (tick && off_reg[k] != '0 && st_reg[k] == ST_OFF) begin
          off_reg[k] <= off_reg[k] - 16'd1;
        end
        if (tick && post_reg[k] != '0) post_reg[k] <= post_reg[k] - 16'd1;
        if (tick && ign_reg[k] != '0) ign_reg[k] <= ign_reg[k] - 16'd1;
        if (tick && comp_run_o[k]) hours_reg[k] <= hours_reg[k] + 32'd1;
        if (tick && run_reg[k] != '1) run_reg[k] <= run_reg[k] + 16'd1;
        if (mrst) oil_diag_reg[k] <= 1'b0;
        if (trip[k] && st_reg[k] != ST_OFF) begin
          st_reg[k] <= ST_OFF;
          off_reg[k] <= LONG_OFF_TK;
          post_reg[k] <= '0;
        end else begin
          case (st_reg[k])
            ST_OFF: begin
              if (start_req[k]) st_reg[k] <= ST_POSITION;
            end
            ST_POSITION: begin
              if (stop_all) begin
                st_reg[k] <= ST_OFF;
              end else if (pos_reg[k] == VALVE_START) begin
                st_reg[k] <= ST_RUN;
                starts_reg[k] <= starts_reg[k] + 16'd1;
                run_reg[k] <= '0;
                ign_reg[k] <= 16'(cond_temp_i) * TK_PER_S;
              end
            end
            ST_RUN: begin
              if (stop_all || stop_req[k]) begin
                st_reg[k] <= ST_UNLOAD;
                tmr_reg[k] <= RUN_UNLOAD_TK;
                off_reg[k] <= (!stop_all && run_reg[k] >= MIN_RUN_TK) ?
                              SHORT_OFF_TK : LONG_OFF_TK;
              end
            end
            ST_UNLOAD: begin
              if (tmr_reg[k] == '0) begin
                st_reg[k] <= ST_OIL;
                tmr_reg[k] <= OIL_TK;
              end
            end
            default: begin
              if (!oil_s[k] || tmr_reg[k] == '0) begin
                st_reg[k] <= ST_OFF;
                post_reg[k] <= POST_TK;
                oil_diag_reg[k] <= oil_s[k];
              end
            end
          endcase
        end
      end
    end
  end

  // registered pin outputs
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < NC; k++) begin
      if (rst_i) begin
        comp_run_o[k] <= 1'b0;
        oil_sol_o[k] <= 1'b0;
        heater_o[k] <= 1'b1;
        load_sol_o[k] <= 1'b0;
        unload_sol_o[k] <= 1'b0;
        fan_en_o[k] <= 1'b0;
        valve_step_o[k] <= 1'b0;
        valve_open_o[k] <= 1'b0;
        lt_ignore_o[k] <= 1'b0;
        pos_reg[k] <= '0;
      end else begin
        comp_run_o[k] <= st_reg[k] >= ST_RUN;
        oil_sol_o[k] <= st_reg[k] == ST_RUN ||
                        st_reg[k] == ST_UNLOAD;
        heater_o[k] <= st_reg[k] < ST_RUN;
        fan_en_o[k] <= st_reg[k] >= ST_RUN;
        lt_ignore_o[k] <= ign_reg[k] != '0;
        load_sol_o[k] <= st_reg[k] == ST_RUN && pulse_reg &&
                         !limit[k] && !chil_lim;
        unload_sol_o[k] <= st_reg[k] == ST_POSITION ||
                           st_reg[k] >= ST_UNLOAD ||
                           (st_reg[k] == ST_OFF && post_reg[k] != '0) ||
                           (st_reg[k] == ST_RUN &&
                            (stg_reg != '0 || limit[k] || chil_lim));
        // valve sits closed while off, at start position otherwise
        valve_open_o[k] <= st_reg[k] != ST_OFF;
        valve_step_o[k] <= 1'b0;
        if (step && st_reg[k] == ST_OFF && pos_reg[k] != '0) begin
          valve_step_o[k] <= 1'b1;
          pos_reg[k] <= pos_reg[k] - 10'd1;
        end else if (step && st_reg[k] != ST_OFF &&
                     pos_reg[k] < VALVE_START) begin
          valve_step_o[k] <= 1'b1;
          pos_reg[k] <= pos_reg[k] + 10'd1;
        end
      end
    end
  end
endmodule // cps_seq
`default_nettype wire

/* cps_seq_asserts.sv */
// port assertions for the compressor sequencer
`default_nettype none
module cps_seq_asserts(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic [1:0] comp_run_o,
  input wire logic [1:0] heater_o,
  input wire logic [1:0] oil_sol_o,
  input wire logic [1:0] load_sol_o,
  input wire logic [1:0] unload_sol_o,
  input wire logic [1:0] valve_step_o,
  input wire logic [1:0] valve_open_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_start_unl: assert property (
    // unload releases with the contactor, so look one edge back
    $rose(comp_run_o[0]) |-> $past(unload_sol_o[0]) && !load_sol_o[0])
    else $error("start not unloaded");
  chk_start_oil: assert property (
    $rose(comp_run_o[0]) |-> oil_sol_o[0]) else $error("oil off at start");
  chk_run_heat: assert property (
    comp_run_o[0] |-> !heater_o[0]) else $error("heater on while running");
  chk_sol_excl: assert property (
    !(load_sol_o[0] && unload_sol_o[0])) else $error("load and unload");
  chk_pos_drv: assert property (
    valve_step_o[0] && valve_open_o[0] |-> unload_sol_o[0] && !comp_run_o[0])
    else $error("valve opened in wrong state");
  chk_stop_close: assert property (
    $fell(comp_run_o[0]) |-> ##[1:8] valve_step_o[0] && !valve_open_o[0])
    else $error("valve not closing after stop");
  chk_stop_heat: assert property (
    $fell(comp_run_o[0]) |-> ##[0:1] heater_o[0] && !oil_sol_o[0])
    else $error("heater or oil wrong after stop");
  chk_wr_resp: assert property (
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##[1:3] s_axi_bvalid_o) else $error("write response late");
endmodule // cps_seq_asserts
`default_nettype wire
